// ==== hw/port_drive_strength_regs.sv ====
// Drive level register bank for ports E, F, G, H and J
//
// How it works
// - Each two-bit field codes the source current level in binary, 00 minimum up to 11 maximum.
// - Upper bits 7 to 4 of the reduced registers read as zero and ignore writes.
// - In the small package the port G/H register keeps only bits 3 to 2, for port G pins 7 to 4.
// - In the small package bits 1 to 0 of the port G/H register read as zero.
// - In the full package bits 7 to 6 of the port G/H register drive port H pins 7 to 4.
// - In the full package bits 5 to 4 of the port G/H register drive port H pins 3 to 0.
// - In the full package bits 1 to 0 drive port G pins 3 to 0 and bits 3 to 2 pins 7 to 4.
// - Bits 1 to 0 of the port J register drive port J pins 3 to 0.
// - Bits 3 to 2 of the port J register drive port J pins 7 to 4.
`timescale 1ns/1ps
`include "drive_level_defs.svh"
module port_drive_strength_regs #(
    parameter bit SMALL_PACKAGE = 1'b0
) (
    // Clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         arst_n,
    // Register port
    input  wire logic [3:0]                   reg_addr,
    input  wire logic [7:0]                   reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic [7:0]                        reg_rdata,
    // Drive level per pin group
    output drive_level_pkg::drive_level_t     port_e_lower_drive,
    output drive_level_pkg::drive_level_t     port_e_upper_drive,
    output drive_level_pkg::drive_level_t     port_f_lower_drive,
    output drive_level_pkg::drive_level_t     port_f_upper_drive,
    output drive_level_pkg::drive_level_t     port_g_lower_drive,
    output drive_level_pkg::drive_level_t     port_g_upper_drive,
    output drive_level_pkg::drive_level_t     port_h_lower_drive,
    output drive_level_pkg::drive_level_t     port_h_upper_drive,
    output drive_level_pkg::drive_level_t     port_j_lower_drive,
    output drive_level_pkg::drive_level_t     port_j_upper_drive
);

    // ==========================================================
    // Decode
    reg_decode_if dec ();

    assign dec.addr = reg_addr;

    reg_decode #(
        .SMALL_PACKAGE (SMALL_PACKAGE)
    ) u_decode (
        .dec (dec)
    );

    // ==========================================================
    // Helpers
    function automatic logic [7:0] merge_bits(
        input logic [7:0] old_val,
        input logic [7:0] new_val,
        input logic [7:0] mask
    );
        merge_bits = (old_val & ~mask) | (new_val & mask);
    endfunction

    function automatic drive_level_pkg::drive_level_t field_level(
        input logic [7:0] val,
        input int         lsb
    );
        field_level = drive_level_pkg::drive_level_t'(val[lsb +: `FIELD_WIDTH]);
    endfunction

    // ==========================================================
    // State
    drive_level_pkg::bank_state_t st;
    drive_level_pkg::bank_state_t next_st;

    always_comb begin
        next_st       = st;
        next_st.rdata = `RESET_READ_DATA;
        if (reg_wr) begin
            // Only implemented bits take the write
            if (dec.sel_ports_e_f) begin
                next_st.ports_e_f = merge_bits(st.ports_e_f, reg_wdata, dec.mask_sel);
            end
            if (dec.sel_ports_g_h) begin
                next_st.ports_g_h = merge_bits(st.ports_g_h, reg_wdata, dec.mask_sel);
            end
            if (dec.sel_port_j) begin
                next_st.port_j = merge_bits(st.port_j, reg_wdata, dec.mask_sel);
            end
        end
        if (reg_rd) begin
            // Unmapped addresses and unimplemented bits read zero
            if (dec.sel_ports_e_f) begin
                next_st.rdata = st.ports_e_f & dec.mask_sel;
            end else if (dec.sel_ports_g_h) begin
                next_st.rdata = st.ports_g_h & dec.mask_sel;
            end else if (dec.sel_port_j) begin
                next_st.rdata = st.port_j & dec.mask_sel;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st.ports_e_f <= `RESET_DRIVE_REG;
            st.ports_g_h <= `RESET_DRIVE_REG;
            st.port_j    <= `RESET_DRIVE_REG;
            st.rdata     <= `RESET_READ_DATA;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rdata          = st.rdata;
    assign port_e_lower_drive = field_level(st.ports_e_f, `PORT_E_LOWER_LSB);
    assign port_e_upper_drive = field_level(st.ports_e_f, `PORT_E_UPPER_LSB);
    assign port_f_lower_drive = field_level(st.ports_e_f, `PORT_F_LOWER_LSB);
    assign port_f_upper_drive = field_level(st.ports_e_f, `PORT_F_UPPER_LSB);
    assign port_g_lower_drive = field_level(st.ports_g_h, `PORT_G_LOWER_LSB);
    assign port_g_upper_drive = field_level(st.ports_g_h, `PORT_G_UPPER_LSB);
    assign port_h_lower_drive = field_level(st.ports_g_h, `PORT_H_LOWER_LSB);
    assign port_h_upper_drive = field_level(st.ports_g_h, `PORT_H_UPPER_LSB);
    assign port_j_lower_drive = field_level(st.port_j, `PORT_J_LOWER_LSB);
    assign port_j_upper_drive = field_level(st.port_j, `PORT_J_UPPER_LSB);

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking

    default disable iff (!arst_n);

    logic wr_ef;
    logic wr_gh;
    logic wr_j;
    logic rd_ef;
    logic rd_gh;
    logic rd_j;
    logic rd_none;

    assign wr_ef = reg_wr && (reg_addr == `ADDR_PORTS_E_F);
    assign wr_gh = reg_wr && (reg_addr == `ADDR_PORTS_G_H);
    assign wr_j  = reg_wr && (reg_addr == `ADDR_PORT_J);
    assign rd_ef = reg_rd && (reg_addr == `ADDR_PORTS_E_F);
    assign rd_gh = reg_rd && (reg_addr == `ADDR_PORTS_G_H);
    assign rd_j  = reg_rd && (reg_addr == `ADDR_PORT_J);
    assign rd_none = reg_rd && !rd_ef && !rd_gh && !rd_j;

    AST_MAX_CODE:
    assert property (wr_ef && reg_wdata[7:6] == 2'h3
                     |=> port_f_upper_drive == drive_level_pkg::LEVEL_MAX)
    else $error("Code 11 did not select the maximum level");

    AST_MIN_CODE:
    assert property (wr_ef && reg_wdata[1:0] == 2'h0
                     |=> port_e_lower_drive == drive_level_pkg::LEVEL_MIN)
    else $error("Code 00 did not select the minimum level");

    AST_J_HIGH_ZERO:
    assert property (rd_j |=> reg_rdata[7:4] == 4'h0)
    else $error("Upper bits of the port J register read nonzero");

    AST_J_HIGH_NO_WRITE:
    assert property (st.port_j[7:4] == 4'h0)
    else $error("Upper bits of the port J register took a write");

    AST_G_SMALL_UPPER:
    assert property (SMALL_PACKAGE && wr_gh
                     |=> port_g_upper_drive == $past(reg_wdata[3:2]))
    else $error("Small package port G upper field did not follow the write");

    AST_G_SMALL_LOW_ZERO:
    assert property (SMALL_PACKAGE && rd_gh |=> reg_rdata[1:0] == 2'h0)
    else $error("Small package bits 1 to 0 read nonzero");

    AST_G_SMALL_LOW_MIN:
    assert property (SMALL_PACKAGE |-> port_g_lower_drive == drive_level_pkg::LEVEL_MIN
                     && port_h_upper_drive == drive_level_pkg::LEVEL_MIN)
    else $error("Small package unimplemented field moved");

    AST_H_UPPER:
    assert property (!SMALL_PACKAGE && wr_gh
                     |=> port_h_upper_drive == $past(reg_wdata[7:6]))
    else $error("Port H upper field did not follow the write");

    AST_H_LOWER:
    assert property (!SMALL_PACKAGE && wr_gh
                     |=> port_h_lower_drive == $past(reg_wdata[5:4]))
    else $error("Port H lower field did not follow the write");

    AST_G_FULL:
    assert property (!SMALL_PACKAGE && wr_gh
                     |=> port_g_lower_drive == $past(reg_wdata[1:0])
                     && port_g_upper_drive == $past(reg_wdata[3:2]))
    else $error("Port G fields did not follow the write");

    AST_J_LOWER:
    assert property (wr_j |=> port_j_lower_drive == $past(reg_wdata[1:0]))
    else $error("Port J lower field did not follow the write");

    AST_J_UPPER:
    assert property (wr_j |=> port_j_upper_drive == $past(reg_wdata[3:2]))
    else $error("Port J upper field did not follow the write");

    AST_EF_LAYOUT:
    assert property (wr_ef |=> {port_f_upper_drive, port_f_lower_drive,
                                port_e_upper_drive, port_e_lower_drive} == $past(reg_wdata))
    else $error("Port E/F fields do not match the written byte");

    AST_READBACK:
    assert property (wr_ef ##1 rd_ef |=> reg_rdata == $past(reg_wdata, 2))
    else $error("Port E/F register did not read back its written value");

    AST_HOLD:
    assert property (!reg_wr |=> $stable(st.ports_e_f) && $stable(st.ports_g_h)
                     && $stable(st.port_j))
    else $error("A drive register changed without a write");

    AST_READ_ONE_CYCLE:
    assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("Read data stood outside the answer cycle");

    AST_GH_SMALL_HIGH_CLEAR:
    assert property (SMALL_PACKAGE |-> st.ports_g_h[7:4] == 4'h0)
    else $error("Upper bits of the small port G/H register took a write");

    AST_GH_SMALL_HIGH_READ:
    assert property (SMALL_PACKAGE && rd_gh |=> reg_rdata[7:4] == 4'h0)
    else $error("Upper bits of the small port G/H register read nonzero");

    AST_GH_SMALL_STORED:
    assert property (SMALL_PACKAGE && wr_gh
                     |=> st.ports_g_h == ($past(reg_wdata) & `MASK_PORT_G_SMALL))
    else $error("Small port G/H register stored unimplemented bits");

    AST_J_STORED:
    assert property (wr_j |=> st.port_j == ($past(reg_wdata) & `MASK_PORT_J))
    else $error("Port J register stored unimplemented bits");

    AST_EF_READ:
    assert property (rd_ef |=> reg_rdata == $past({port_f_upper_drive, port_f_lower_drive,
                                                  port_e_upper_drive, port_e_lower_drive}))
    else $error("Port E/F read data differ from the drive fields");

    AST_GH_FULL_READ:
    assert property (!SMALL_PACKAGE && rd_gh
                     |=> reg_rdata == $past({port_h_upper_drive, port_h_lower_drive,
                                             port_g_upper_drive, port_g_lower_drive}))
    else $error("Port G/H read data differ from the drive fields");

    AST_GH_SMALL_READ:
    assert property (SMALL_PACKAGE && rd_gh
                     |=> reg_rdata == {4'h0, $past(port_g_upper_drive), 2'h0})
    else $error("Small port G/H read data differ from the port G upper field");

    AST_J_READ:
    assert property (rd_j |=> reg_rdata == {4'h0, $past(port_j_upper_drive),
                                            $past(port_j_lower_drive)})
    else $error("Port J read data differ from the drive fields");

    AST_EF_UNTOUCHED:
    assert property (reg_wr && !wr_ef |=> $stable(st.ports_e_f))
    else $error("Port E/F register changed on a write elsewhere");

    AST_GH_UNTOUCHED:
    assert property (reg_wr && !wr_gh |=> $stable(st.ports_g_h))
    else $error("Port G/H register changed on a write elsewhere");

    AST_J_UNTOUCHED:
    assert property (reg_wr && !wr_j |=> $stable(st.port_j))
    else $error("Port J register changed on a write elsewhere");

    AST_RESET_CLEAR:
    assert property ($rose(arst_n) |-> reg_rdata == `RESET_READ_DATA
                     && st.ports_e_f == `RESET_DRIVE_REG && st.ports_g_h == `RESET_DRIVE_REG
                     && st.port_j == `RESET_DRIVE_REG)
    else $error("Register bank did not start from its reset values");

    AST_UNMAPPED_READ:
    assert property (rd_none |=> reg_rdata == 8'h00)
    else $error("Read of an unmapped address returned nonzero data");

    COV_MAX_LEVEL:
    cover property (wr_j && reg_wdata[3:2] == 2'h3 ##1
                    port_j_upper_drive == drive_level_pkg::LEVEL_MAX);

    COV_READBACK:
    cover property (wr_gh ##1 rd_gh ##1 reg_rdata != 8'h00);

    COV_BACK_TO_BACK_WRITES:
    cover property (wr_ef ##1 wr_gh ##1 wr_j);

    COV_UNMAPPED_READ:
    cover property (reg_rd && !dec.sel_ports_e_f && !dec.sel_ports_g_h
                    && !dec.sel_port_j);

    COV_SMALL_G_READ:
    cover property (SMALL_PACKAGE && rd_gh ##1 reg_rdata[3:2] != 2'h0);

endmodule

// ==== hw/drive_level_defs.svh ====
// Register offsets, field positions, masks and reset values of the drive level bank
`ifndef DRIVE_LEVEL_DEFS_SVH
`define DRIVE_LEVEL_DEFS_SVH

// ==========================================================
// Register offsets
`define ADDR_PORTS_E_F      4'h0
`define ADDR_PORTS_G_H      4'h1
`define ADDR_PORT_J         4'h2

// ==========================================================
// Field positions, each field two bits wide
`define FIELD_WIDTH         2
`define PORT_E_LOWER_LSB    0
`define PORT_E_UPPER_LSB    2
`define PORT_F_LOWER_LSB    4
`define PORT_F_UPPER_LSB    6
`define PORT_G_LOWER_LSB    0
`define PORT_G_UPPER_LSB    2
`define PORT_H_LOWER_LSB    4
`define PORT_H_UPPER_LSB    6
`define PORT_J_LOWER_LSB    0
`define PORT_J_UPPER_LSB    2

// ==========================================================
// Implemented bit masks
`define MASK_PORTS_E_F      8'hFF
`define MASK_PORTS_G_H_FULL 8'hFF
`define MASK_PORT_G_SMALL   8'h0C
`define MASK_PORT_J         8'h0F
`define MASK_NONE           8'h00

// ==========================================================
// Reset values
`define RESET_DRIVE_REG     8'h00
`define RESET_READ_DATA     8'h00

`endif

// ==== hw/drive_level_pkg.sv ====
// Types shared by the drive level register bank
package drive_level_pkg;

    // Source current level, binary coded from minimum to maximum
    typedef enum logic [1:0] {
        LEVEL_MIN,
        LEVEL_1,
        LEVEL_2,
        LEVEL_MAX
    } drive_level_t;

    // Whole state of the register bank
    typedef struct packed {
        logic [7:0] ports_e_f;
        logic [7:0] ports_g_h;
        logic [7:0] port_j;
        logic [7:0] rdata;
    } bank_state_t;

endpackage

// ==== hw/reg_decode_if.sv ====
// Address decode signals between the register core and its decoder
`timescale 1ns/1ps
interface reg_decode_if;
    logic [3:0] addr;
    logic       sel_ports_e_f;
    logic       sel_ports_g_h;
    logic       sel_port_j;
    logic [7:0] mask_sel;

    modport core (
        output addr,
        input  sel_ports_e_f,
        input  sel_ports_g_h,
        input  sel_port_j,
        input  mask_sel
    );

    modport decoder (
        input  addr,
        output sel_ports_e_f,
        output sel_ports_g_h,
        output sel_port_j,
        output mask_sel
    );
endinterface

// ==== hw/reg_decode.sv ====
// Address decoder giving register selects and implemented bit masks
`timescale 1ns/1ps
`include "drive_level_defs.svh"
module reg_decode #(
    parameter bit SMALL_PACKAGE = 1'b0
) (
    // Decode link to the register core
    reg_decode_if.decoder dec
);

    always_comb begin
        dec.sel_ports_e_f = (dec.addr == `ADDR_PORTS_E_F);
        dec.sel_ports_g_h = (dec.addr == `ADDR_PORTS_G_H);
        dec.sel_port_j    = (dec.addr == `ADDR_PORT_J);
        dec.mask_sel      = `MASK_NONE;
        if (dec.sel_ports_e_f) begin
            dec.mask_sel = `MASK_PORTS_E_F;
        end else if (dec.sel_ports_g_h) begin
            // Small package has only the upper port G field
            dec.mask_sel = SMALL_PACKAGE ? `MASK_PORT_G_SMALL : `MASK_PORTS_G_H_FULL;
        end else if (dec.sel_port_j) begin
            dec.mask_sel = `MASK_PORT_J;
        end
    end

endmodule

// ==== verif/test_port_drive_strength_regs.sv ====
// Self-checking bench for the drive level bank, full and small package side by side
`timescale 1ns/1ps
`include "drive_level_defs.svh"
module test_port_drive_strength_regs;
    // ==========================================================
    // Signals
    logic        ref_clk    = 1'b0;
    logic        arst_n     = 1'b0;
    logic [3:0]  reg_addr   = 4'h0;
    logic [7:0]  reg_wdata  = 8'h00;
    logic        reg_wr     = 1'b0;
    logic        reg_rd     = 1'b0;
    wire  [7:0]  rd_full;
    wire  [7:0]  rd_small;
    wire  [19:0] lv_full;
    wire  [19:0] lv_small;
    logic [7:0]  sh_ef      = 8'h00;
    logic [7:0]  sh_gh      = 8'h00;
    logic [7:0]  sh_j       = 8'h00;
    int          n_errors   = 0;
    int          num_checks = 0;
    string       fname [10] = '{"e_lo", "e_up", "f_lo", "f_up", "g_lo", "g_up", "h_lo", "h_up",
                                "j_lo", "j_up"};

    initial forever #20 ref_clk = ~ref_clk;

    // ==========================================================
    // Both variants on one register port
    port_drive_strength_regs #(.SMALL_PACKAGE(1'b0)) u_port_drive_strength_regs (
        .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rd_full),
        .port_e_lower_drive(lv_full[1:0]), .port_e_upper_drive(lv_full[3:2]),
        .port_f_lower_drive(lv_full[5:4]), .port_f_upper_drive(lv_full[7:6]),
        .port_g_lower_drive(lv_full[9:8]), .port_g_upper_drive(lv_full[11:10]),
        .port_h_lower_drive(lv_full[13:12]), .port_h_upper_drive(lv_full[15:14]),
        .port_j_lower_drive(lv_full[17:16]), .port_j_upper_drive(lv_full[19:18]));
    port_drive_strength_regs #(.SMALL_PACKAGE(1'b1)) u_port_drive_strength_regs_small (
        .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rd_small),
        .port_e_lower_drive(lv_small[1:0]), .port_e_upper_drive(lv_small[3:2]),
        .port_f_lower_drive(lv_small[5:4]), .port_f_upper_drive(lv_small[7:6]),
        .port_g_lower_drive(lv_small[9:8]), .port_g_upper_drive(lv_small[11:10]),
        .port_h_lower_drive(lv_small[13:12]), .port_h_upper_drive(lv_small[15:14]),
        .port_j_lower_drive(lv_small[17:16]), .port_j_upper_drive(lv_small[19:18]));

    // ==========================================================
    // Compare, access and check tasks
    function automatic drive_level_pkg::drive_level_t lvl(input logic [19:0] v, input int i);
        return drive_level_pkg::drive_level_t'(v[2*i +: 2]);
    endfunction

    task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cmp_lvl(input string name, input drive_level_pkg::drive_level_t exp,
                           input drive_level_pkg::drive_level_t got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    // Entered at a rising edge; shadow keeps the full written byte
    // Keep leaves the strobe up for a write in the very next cycle
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input bit keep = 1'b0);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        if (!keep) begin
            reg_wr <= 1'b0;
        end
        case (a)
            `ADDR_PORTS_E_F: sh_ef = d;
            `ADDR_PORTS_G_H: sh_gh = d;
            `ADDR_PORT_J:    sh_j = d;
            default: ;
        endcase
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] df, output logic [7:0] ds);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        df = rd_full;
        ds = rd_small;
        @(posedge ref_clk);
    endtask

    // Small package keeps G/H bits 3..2 only; J keeps bits 3..0 in both
    task automatic check_all();
        logic [19:0] exp_f;
        logic [19:0] exp_s;
        logic [7:0]  df;
        logic [7:0]  ds;
        exp_f = {sh_j[3:0], sh_gh, sh_ef};
        exp_s = {sh_j[3:0], sh_gh & 8'h0C, sh_ef};
        @(negedge ref_clk);
        for (int i = 0; i < 10; i++) begin
            cmp_lvl({"full ", fname[i]}, lvl(exp_f, i), lvl(lv_full, i));
            cmp_lvl({"small ", fname[i]}, lvl(exp_s, i), lvl(lv_small, i));
        end
        @(posedge ref_clk);
        rd(`ADDR_PORTS_E_F, df, ds);
        cmp8("full e_f", sh_ef, df);
        cmp8("small e_f", sh_ef, ds);
        rd(`ADDR_PORTS_G_H, df, ds);
        cmp8("full g_h", sh_gh, df);
        cmp8("small g_h", sh_gh & 8'h0C, ds);
        rd(`ADDR_PORT_J, df, ds);
        cmp8("full j", sh_j & 8'h0F, df);
        cmp8("small j", sh_j & 8'h0F, ds);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        n_errors++;
        $display("mismatch watchdog expected finish seen hang");
        complete_run();
    end

    // ==========================================================
    // Test sequence
    initial begin
        logic [7:0] df;
        logic [7:0] ds;
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        check_all();
        $display("test reset values done");
        for (int c = 0; c < 4; c++) begin
            wr(`ADDR_PORTS_E_F, {4{c[1:0]}}, 1'b1);
            wr(`ADDR_PORTS_G_H, {4{c[1:0]}}, 1'b1);
            wr(`ADDR_PORT_J, {4{c[1:0]}});
            check_all();
        end
        $display("test every level code done");
        wr(`ADDR_PORTS_E_F, 8'hE4, 1'b1);
        wr(`ADDR_PORTS_G_H, 8'hE4, 1'b1);
        wr(`ADDR_PORT_J, 8'hFB);
        check_all();
        wr(`ADDR_PORTS_E_F, 8'h1B, 1'b1);
        wr(`ADDR_PORTS_G_H, 8'h1B, 1'b1);
        wr(`ADDR_PORT_J, 8'hF4);
        check_all();
        $display("test distinct fields done");
        wr(4'h3, 8'hFF, 1'b1);
        wr(4'hF, 8'hFF);
        check_all();
        rd(4'hF, df, ds);
        cmp8("full unmapped", 8'h00, df);
        cmp8("small unmapped", 8'h00, ds);
        $display("test unmapped address done");
        wr(`ADDR_PORTS_E_F, 8'hC6);
        rd(`ADDR_PORTS_E_F, df, ds);
        cmp8("full e_f after write", 8'hC6, df);
        cmp8("small e_f after write", 8'hC6, ds);
        wr(`ADDR_PORTS_G_H, 8'h5A);
        rd(`ADDR_PORTS_G_H, df, ds);
        cmp8("full g_h after write", 8'h5A, df);
        cmp8("small g_h after write", 8'h08, ds);
        @(negedge ref_clk);
        cmp8("full idle read data", 8'h00, rd_full);
        cmp8("small idle read data", 8'h00, rd_small);
        @(posedge ref_clk);
        $display("test back to back access done");
        arst_n <= 1'b0;
        sh_ef = 8'h00;
        sh_gh = 8'h00;
        sh_j  = 8'h00;
        @(negedge ref_clk);
        cmp8("full reset read data", 8'h00, rd_full);
        cmp8("small reset read data", 8'h00, rd_small);
        for (int i = 0; i < 10; i++) begin
            cmp_lvl({"full reset ", fname[i]}, drive_level_pkg::LEVEL_MIN, lvl(lv_full, i));
            cmp_lvl({"small reset ", fname[i]}, drive_level_pkg::LEVEL_MIN, lvl(lv_small, i));
        end
        @(posedge ref_clk);
        arst_n <= 1'b1;
        check_all();
        $display("test reset in mid-run done");
        complete_run();
    end
endmodule
